// File: instr_exec_pkg.sv
package instr_exec_pkg;

  localparam int DATA_W = 8;
  localparam int ROM_W = 14;
  localparam int PTR_W = 3;
  localparam int ROM_AW = PTR_W + DATA_W;
  localparam int REG_AW = 7;
  localparam int TABLE_HIGH_W = 6;
  localparam int ROM_LO_MSB = 7;
  localparam int ROM_HI_LSB = 8;
  localparam int ROM_HI_MSB = 13;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TMODE_RESET = 8'h00;
  localparam logic [TABLE_HIGH_W-1:0] TABLE_HIGH_RESET = 6'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_TABLE_READ = 3'b001,
    OP_TMODE_READ = 3'b010,
    OP_TMODE_WRITE = 3'b011,
    OP_XOR_REG = 3'b100,
    OP_XOR_IMM = 3'b101
  } op_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic dest;
    logic [REG_AW-1:0] reg_addr;
    logic [DATA_W-1:0] imm;
  } instr_type;

  typedef struct packed {
    logic we;
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_TABLE = 1'b1
  } state_type;

endpackage

// File: table_read_xor_instr_exec.sv
// Overview of operation
// - Table read: ROM address {pointer[2:0], acc}; low byte to acc in two cycles.
// - Table read also puts ROM bits 13..8 into table-high data bits 5..0.
// - Timer-mode read copies timer0 mode into acc in one cycle, flags kept.
// - Register XOR, dest 0: acc gets acc^reg, only zero flag, one cycle.
// - Register XOR, dest 1: result written back to register, acc kept.
// - Immediate XOR: acc gets acc^imm, zero flag updated, one cycle.
// - Timer0 mode only written by companion load-from-acc instruction, one cycle.
`timescale 1ns/1ps
module table_read_xor_instr_exec
  import instr_exec_pkg::*;
(
  input wire logic mclk, // Instruction clock
  input wire logic rst, // Sync reset, active high
  input wire instr_type instr, // Decoded instruction
  input wire logic [PTR_W-1:0] table_high_pointer, // Table page pointer
  input wire logic [ROM_W-1:0] rom_data, // ROM word for rom_addr, valid in the same cycle
  input wire logic [DATA_W-1:0] reg_rdata, // File register read data
  output logic busy, // Table read second cycle
  output logic [ROM_AW-1:0] rom_addr, // ROM table address
  output logic [REG_AW-1:0] reg_raddr, // File register read address
  output reg_write_type reg_wr, // File register write
  output logic [DATA_W-1:0] acc, // Accumulator
  output logic [DATA_W-1:0] timer0_mode_register, // Timer0 mode
  output logic [TABLE_HIGH_W-1:0] table_high_data, // Table high data
  output logic zero_flag // Zero flag
);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  state_type state, next_state;
  logic [ROM_AW-1:0] next_rom_addr;
  logic [DATA_W-1:0] next_acc, next_tmode, xor_res;
  logic [TABLE_HIGH_W-1:0] next_table_high_data;
  logic next_zero, next_busy;
  reg_write_type next_wr;
  logic take;

  // Unregistered so register data returns within the same cycle
  assign reg_raddr = instr.reg_addr;
  assign take = instr.valid && state == ST_IDLE;

  always_comb begin
    next_state = state;
    next_rom_addr = rom_addr;
    next_acc = acc;
    next_tmode = timer0_mode_register;
    next_table_high_data = table_high_data;
    next_zero = zero_flag;
    next_wr = '0;
    xor_res = acc ^ ((instr.op == OP_XOR_IMM) ? instr.imm : reg_rdata);
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          unique case (instr.op)
            OP_TABLE_READ: begin
              next_rom_addr = {table_high_pointer, acc};
              next_state = ST_TABLE;
            end
            OP_TMODE_READ: next_acc = timer0_mode_register;
            OP_TMODE_WRITE: next_tmode = acc;
            OP_XOR_REG: begin
              next_zero = (xor_res == BYTE_ZERO);
              if (instr.dest) begin
                next_wr = '{we: 1'b1, addr: instr.reg_addr, data: xor_res};
              end else begin
                next_acc = xor_res;
              end
            end
            OP_XOR_IMM: begin
              next_acc = xor_res;
              next_zero = (xor_res == BYTE_ZERO);
            end
            default: ;
          endcase
        end
      end
      ST_TABLE: begin
        next_acc = rom_data[ROM_LO_MSB:0];
        next_table_high_data = rom_data[ROM_HI_MSB:ROM_HI_LSB];
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state == ST_TABLE);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      rom_addr <= '0;
      acc <= ACC_RESET;
      timer0_mode_register <= TMODE_RESET;
      table_high_data <= TABLE_HIGH_RESET;
      zero_flag <= FLAG_RESET;
      reg_wr <= '0;
      busy <= FLAG_RESET;
    end else begin
      state <= next_state;
      rom_addr <= next_rom_addr;
      acc <= next_acc;
      timer0_mode_register <= next_tmode;
      table_high_data <= next_table_high_data;
      zero_flag <= next_zero;
      reg_wr <= next_wr;
      busy <= next_busy;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_table_two_cycle: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TABLE_READ |=> busy ##1 (!busy && acc == $past(rom_data[ROM_LO_MSB:0])))
    else $error("table read did not load acc after two cycles");
  chk_table_addr: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TABLE_READ |=> rom_addr == {$past(table_high_pointer), $past(acc)})
    else $error("table address wrong");
  chk_table_high: assert property (@(posedge mclk) disable iff (rst)
    busy |=> table_high_data == $past(rom_data[ROM_HI_MSB:ROM_HI_LSB]))
    else $error("table high data wrong");
  chk_tmode_read: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TMODE_READ |=> acc == $past(timer0_mode_register) && $stable(zero_flag))
    else $error("timer mode read wrong");
  chk_xor_reg_acc: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG && !instr.dest |=> acc == ($past(acc) ^ $past(reg_rdata)) && !reg_wr.we)
    else $error("register xor to acc wrong");
  chk_xor_reg_back: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG && instr.dest |=> reg_wr.we && $stable(acc)
      && reg_wr.data == ($past(acc) ^ $past(reg_rdata)))
    else $error("register xor write back wrong");
  chk_xor_imm: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_IMM |=> acc == ($past(acc) ^ $past(instr.imm)))
    else $error("immediate xor wrong");
  chk_tmode_write: assert property (@(posedge mclk) disable iff (rst)
    !(take && instr.op == OP_TMODE_WRITE) |=> $stable(timer0_mode_register))
    else $error("timer mode changed without load");
  chk_zero_flag: assert property (@(posedge mclk) disable iff (rst)
    take && (instr.op == OP_XOR_IMM || instr.op == OP_XOR_REG)
      |=> zero_flag
        == (($past(acc) ^ $past(instr.op == OP_XOR_IMM ? instr.imm : reg_rdata)) == BYTE_ZERO))
    else $error("zero flag wrong");

  // ----------------------------------------
  // Table read sequencing checks
  // ----------------------------------------
  chk_busy_blocks_take: assert property (@(posedge mclk) disable iff (rst)
    busy |-> !take)
    else $error("instruction taken while busy");
  chk_busy_one_cycle: assert property (@(posedge mclk) disable iff (rst)
    busy |=> !busy)
    else $error("busy held longer than one cycle");
  chk_table_hold_acc: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TABLE_READ |=> $stable(acc) && $stable(zero_flag) && !reg_wr.we)
    else $error("table read changed state in its first cycle");
  chk_busy_ignores: assert property (@(posedge mclk) disable iff (rst)
    busy |=> $stable(timer0_mode_register) && $stable(zero_flag) && !reg_wr.we)
    else $error("instruction acted on while busy");
  chk_rom_addr_hold: assert property (@(posedge mclk) disable iff (rst)
    !(take && instr.op == OP_TABLE_READ) |=> $stable(rom_addr))
    else $error("table address moved without a table read");
  chk_table_page: assert property (@(posedge mclk) disable iff (rst)
    busy |-> rom_addr[ROM_AW-1:DATA_W] == $past(table_high_pointer))
    else $error("table page not taken from pointer");
  chk_high_only_table: assert property (@(posedge mclk) disable iff (rst)
    !busy |=> $stable(table_high_data))
    else $error("table high data changed outside a table read");

  // ----------------------------------------
  // Timer mode checks
  // ----------------------------------------
  chk_tmode_read_keep: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TMODE_READ
      |=> !reg_wr.we && $stable(timer0_mode_register) && $stable(table_high_data) && !busy)
    else $error("timer mode read disturbed other state");
  chk_tmode_load: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_TMODE_WRITE
      |=> timer0_mode_register == $past(acc) && $stable(acc) && $stable(zero_flag))
    else $error("timer mode load wrong");

  // ----------------------------------------
  // Exclusive-OR checks
  // ----------------------------------------
  chk_reg_read_addr: assert property (@(posedge mclk) disable iff (rst)
    reg_raddr == instr.reg_addr)
    else $error("register read address wrong");
  chk_xor_reg_keep: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG
      |=> $stable(timer0_mode_register) && $stable(table_high_data))
    else $error("register xor disturbed other state");
  chk_acc_idle_hold: assert property (@(posedge mclk) disable iff (rst)
    !take && !busy |=> $stable(acc))
    else $error("acc changed with no instruction");
  chk_xor_wr_addr: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG && instr.dest |=> reg_wr.addr == $past(instr.reg_addr))
    else $error("register xor write address wrong");
  chk_wr_source: assert property (@(posedge mclk) disable iff (rst)
    reg_wr.we |-> $past(take && instr.op == OP_XOR_REG && instr.dest))
    else $error("register write without register xor");
  chk_xor_imm_keep: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_IMM |=> !reg_wr.we && $stable(timer0_mode_register) && !busy)
    else $error("immediate xor disturbed other state");

  // ----------------------------------------
  // Flag checks
  // ----------------------------------------
  chk_zero_after_imm: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_IMM |=> zero_flag == (acc == BYTE_ZERO))
    else $error("zero flag disagrees with immediate result");
  chk_zero_after_acc: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG && !instr.dest |=> zero_flag == (acc == BYTE_ZERO))
    else $error("zero flag disagrees with acc result");
  chk_zero_after_wr: assert property (@(posedge mclk) disable iff (rst)
    take && instr.op == OP_XOR_REG && instr.dest |=> zero_flag == (reg_wr.data == BYTE_ZERO))
    else $error("zero flag disagrees with written result");
  chk_zero_kept: assert property (@(posedge mclk) disable iff (rst)
    !(take && (instr.op == OP_XOR_IMM || instr.op == OP_XOR_REG)) |=> $stable(zero_flag))
    else $error("zero flag changed outside exclusive-or");

endmodule

// File: table_read_xor_instr_exec_tb.sv
`timescale 1ns/1ps
module table_read_xor_instr_exec_tb;
  import instr_exec_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  instr_type instr = '0;
  logic [PTR_W-1:0] table_high_pointer = 3'h0;
  logic [DATA_W-1:0] reg_rdata = 8'h00;
  logic [ROM_W-1:0] rom_data;
  logic busy, zero_flag;
  logic [ROM_AW-1:0] rom_addr;
  logic [REG_AW-1:0] reg_raddr;
  reg_write_type reg_wr;
  logic [DATA_W-1:0] acc, timer0_mode_register;
  logic [TABLE_HIGH_W-1:0] table_high_data;
  int err_count = 0;
  int cmp_count = 0;
  // Stand-in ROM word derived from its address
  assign rom_data = {rom_addr[10:8], rom_addr[2:0], ~rom_addr[7:0]};
  table_read_xor_instr_exec dut (.mclk(mclk), .rst(rst), .instr(instr),
    .table_high_pointer(table_high_pointer), .rom_data(rom_data), .reg_rdata(reg_rdata),
    .busy(busy), .rom_addr(rom_addr), .reg_raddr(reg_raddr), .reg_wr(reg_wr), .acc(acc),
    .timer0_mode_register(timer0_mode_register), .table_high_data(table_high_data),
    .zero_flag(zero_flag));
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input op_type o, input logic d, input logic [7:0] a);
    instr <= '{1'b1, o, d, a[6:0], a};
    @(posedge mclk);
    #1;
  endtask
  task automatic t_xor();
    chk(acc, 8'h00);
    chk(zero_flag, 1'b0);
    issue(OP_XOR_IMM, 1'b0, 8'hF0);
    chk(acc, 8'hF0);
    chk(zero_flag, 1'b0);
    issue(OP_XOR_IMM, 1'b0, 8'hF0);
    chk({zero_flag, acc}, 9'h100);
    reg_rdata = 8'hA5;
    issue(OP_XOR_REG, 1'b0, 8'h11);
    chk({reg_wr.we, acc}, 9'h0A5);
    chk(reg_raddr, 7'h11);
    reg_rdata = 8'hF0;
    issue(OP_XOR_REG, 1'b1, 8'h05);
    chk(reg_wr, {1'b1, 7'h05, 8'h55});
    chk(reg_raddr, 7'h05);
    chk({zero_flag, acc}, 9'h0A5);
    issue(OP_NONE, 1'b0, 8'h00);
    chk(reg_wr.we, 1'b0);
    $display("t_xor done");
  endtask
  task automatic t_mode();
    issue(OP_TMODE_WRITE, 1'b0, 8'h00);
    chk(timer0_mode_register, 8'hA5);
    issue(OP_XOR_IMM, 1'b0, 8'hA5);
    chk({zero_flag, timer0_mode_register}, 9'h1A5);
    issue(OP_TMODE_READ, 1'b0, 8'h00);
    chk({zero_flag, acc}, 9'h1A5);
    $display("t_mode done");
  endtask
  task automatic t_table();
    table_high_pointer = 3'h2;
    issue(OP_XOR_IMM, 1'b0, 8'h91);
    issue(OP_TABLE_READ, 1'b0, 8'h00);
    chk({busy, rom_addr}, 12'hA34);
    // Sent while busy, must be dropped
    issue(OP_XOR_IMM, 1'b0, 8'hFF);
    chk({busy, acc}, 9'h0CB);
    chk(table_high_data, 6'h14);
    issue(OP_NONE, 1'b0, 8'h00);
    chk(acc, 8'hCB);
    $display("t_table done");
  endtask
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({busy, acc, zero_flag}, 10'h000);
    chk({timer0_mode_register, table_high_data}, 14'h0000);
    chk(reg_wr, 16'h0000);
    rst = 1'b0;
    issue(OP_XOR_IMM, 1'b0, 8'h3C);
    chk({zero_flag, acc}, 9'h03C);
    $display("t_reset done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(40 * 200);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_xor();
    t_mode();
    t_table();
    t_reset();
    tally_and_finish();
  end
endmodule
